// ---- hdl/sd_access_map.vh ----
`ifndef SD_ACCESS_MAP_VH
`define SD_ACCESS_MAP_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define CFG_OFS 12'h000
`define SIZE_OFS 12'h004
`define STAT_OFS 12'h008
`define CNT_OFS 12'h00c
`define SLOT_PAGE 6'h01
`define OUT_PAGE 5'h01
`define VAR_BASE 12'h100

// ---------------------------------------------------------------
// configuration fields
// ---------------------------------------------------------------
`define CFG_SLOTS_LSB 0
`define CFG_FMT_LSB 2
`define CFG_SD_BIT 4
`define CFG_RST 5'h00
`define IMG_WORDS_RST 5'h02
`define FMT_INT 2'h0
`define FMT_DIV 2'h1
`define FMT_FLT 2'h2

// ---------------------------------------------------------------
// shared data codes
// ---------------------------------------------------------------
`define CMD_NULL 16'h0000
`define CMD_READ 16'h0001
`define CMD_WRITE 16'h0002
`define ST_NULL 3'h0
`define ST_OK 3'h1
`define ST_BADNAME 3'h2
`define ST_BADCMD 3'h3
`define ST_WPROT 3'h4

// ---------------------------------------------------------------
// image layout, in 16-bit words
// ---------------------------------------------------------------
`define SLOT_IN_MAX 16
`define IMG_MAX 28
`define SD_TOTAL_INT 5'h17
`define SD_TOTAL_FLT 5'h1c
`define SD_IN_BASE_INT 5'h08
`define SD_IN_BASE_FLT 5'h10
`define SD_OUT_BASE_INT 5'h08
`define SD_OUT_BASE_FLT 5'h0d
`define SD_NAME_OFS 1
`define SD_NAME_W 4
`define SD_VAL_OFS 5
`define SD_VAL_W 10

// ---------------------------------------------------------------
// variable table entry layout
// ---------------------------------------------------------------
`define VAR_WORDS 15
`define VAR_ATTR 4
`define ATTR_TEXT_BIT 0
`define ATTR_WP_BIT 1
`define TXT_LO 8'h20
`define TXT_HI 8'h7e

`endif

// ---- hdl/sd_var_store.v ----
`timescale 1ns/1ps
`include "sd_access_map.vh"

module sd_var_store #(
  parameter NVARS = 4,
  parameter VW = 2
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire sw_we_i,
  input wire [VW-1:0] sw_var_i,
  input wire [3:0] sw_word_i,
  input wire [15:0] sw_wdata_i,
  output wire [15:0] sw_rdata_o,
  input wire [63:0] name_i,
  output reg hit_o,
  output reg text_o,
  output reg wp_o,
  output reg [159:0] value_o,
  input wire wr_en_i,
  input wire [159:0] wr_value_i
);

  reg [15:0] mem_reg [0:NVARS*`VAR_WORDS-1];
  wire [NVARS-1:0] match;
  reg [VW-1:0] hit_idx;
  integer i;
  integer k;

  // ---------------------------------------------------------------
  // name match, one comparator per entry
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NVARS; g = g + 1) begin : gen_match
      assign match[g] = {mem_reg[g*`VAR_WORDS+3], mem_reg[g*`VAR_WORDS+2],
                         mem_reg[g*`VAR_WORDS+1], mem_reg[g*`VAR_WORDS]} == name_i;
    end
  endgenerate

  // lowest matching entry wins if software loads a name twice
  always @* begin
    hit_o = 1'b0;
    hit_idx = {VW{1'b0}};
    for (i = NVARS - 1; i >= 0; i = i - 1) begin
      if (match[i]) begin
        hit_o = 1'b1;
        hit_idx = i[VW-1:0];
      end
    end
    text_o = mem_reg[hit_idx*`VAR_WORDS+`VAR_ATTR][`ATTR_TEXT_BIT];
    wp_o = mem_reg[hit_idx*`VAR_WORDS+`VAR_ATTR][`ATTR_WP_BIT];
    for (k = 0; k < `SD_VAL_W; k = k + 1) begin
      value_o[16*k +: 16] = mem_reg[hit_idx*`VAR_WORDS+`SD_VAL_OFS+k];
    end
  end

  assign sw_rdata_o = mem_reg[sw_var_i*`VAR_WORDS+sw_word_i];

  // ---------------------------------------------------------------
  // storage; a link write beats a software write in the same cycle
  // ---------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < NVARS*`VAR_WORDS; i = i + 1) begin
        mem_reg[i] <= 16'h0000;
      end
    end else begin
      if (sw_we_i && sw_word_i < `VAR_WORDS) begin
        mem_reg[sw_var_i*`VAR_WORDS+sw_word_i] <= sw_wdata_i;
      end
      if (wr_en_i) begin
        for (i = 0; i < `SD_VAL_W; i = i + 1) begin
          mem_reg[hit_idx*`VAR_WORDS+`SD_VAL_OFS+i] <= wr_value_i[16*i +: 16];
        end
      end
    end
  end

endmodule // sd_var_store

// ---- hdl/sd_exchange.v ----
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "sd_access_map.vh"

// Behaviour
// [R01] one to four identical message slots
// [R02] one format for the whole image
// [R03] master reads inputs, then writes outputs
// [R04] image size from slots, format, shared data
// [R05] each slot owns its input and output words
// [R06] shared data words only when enabled
// [R07] value fields at most ten words
// [R08] master sends command, names, write value
// [R09] master write value at most twenty bytes
// [R10] command 0 none, 1 read, 2 write
// [R11] inputs hold status and read field
// [R12] read field filled only after read
// [R13] status codes zero through four
// [R14] refuse write of mismatched value type
// [R15] run command once per new value
// [R16] master toggles null/read for repeated reads
// [R17] master loads names while command null
// [R18] master checks integrity bits before use
// [R19] integer slot: two words each way
// [R20] float slot: four in, three out, offset
// [R21] shared data image 23 or 28 words
// [R22] new command is change from last cycle

module sd_exchange #(
  parameter NVARS = 4,
  parameter VW = 2
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [11:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire link_wr_i,
  input wire [4:0] link_waddr_i,
  input wire [15:0] link_wdata_i,
  input wire link_rd_i,
  input wire [4:0] link_raddr_i,
  output wire [15:0] link_rdata_o,
  input wire link_cycle_end_i,
  output wire [4:0] image_words_o
);

  reg [4:0] cfg_reg;
  reg [15:0] slot_in_reg [0:`SLOT_IN_MAX-1];
  reg [15:0] out_img_reg [0:`IMG_MAX-1];
  reg [15:0] prev_cmd_reg;
  reg [2:0] status_reg;
  reg rd_valid_reg;
  reg [159:0] rd_val_reg;
  reg [15:0] cycle_cnt_reg;
  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [15:0] link_rdata_reg;
  reg [4:0] image_words_reg;
  reg [15:0] sd_cmd;
  reg [63:0] sd_name;
  reg [159:0] sd_wval;
  reg [15:0] link_rd_next;
  reg [31:0] av_next;
  integer i;

  // ---------------------------------------------------------------
  // layout
  // ---------------------------------------------------------------
  wire [2:0] slots = {1'b0, cfg_reg[`CFG_SLOTS_LSB+1:`CFG_SLOTS_LSB]} + 3'h1; // see [R01]
  wire flt = cfg_reg[`CFG_FMT_LSB+1:`CFG_FMT_LSB] == `FMT_FLT; // see [R02]
  wire sd_en = cfg_reg[`CFG_SD_BIT]; // see [R06]
  // float output slots start one word in, so both sides use four words per slot
  wire [4:0] slot_words = flt ? {slots, 2'b00} : {1'b0, slots, 1'b0}; // see [R19] see [R20]
  wire [4:0] size_words = sd_en ? (flt ? `SD_TOTAL_FLT : `SD_TOTAL_INT) : slot_words; // see [R04] see [R21]
  wire [4:0] sd_in_base = flt ? `SD_IN_BASE_FLT : `SD_IN_BASE_INT;
  wire [4:0] sd_out_base = flt ? `SD_OUT_BASE_FLT : `SD_OUT_BASE_INT;
  wire [4:0] rel = link_raddr_i - sd_in_base;

  // ---------------------------------------------------------------
  // shared data output fields
  // ---------------------------------------------------------------
  always @* begin
    sd_cmd = out_img_reg[sd_out_base]; // see [R08]
    for (i = 0; i < `SD_NAME_W; i = i + 1) begin
      sd_name[16*i +: 16] = out_img_reg[sd_out_base+`SD_NAME_OFS+i];
    end
    for (i = 0; i < `SD_VAL_W; i = i + 1) begin
      sd_wval[16*i +: 16] = out_img_reg[sd_out_base+`SD_VAL_OFS+i]; // see [R07] see [R09]
    end
  end

  wire hit;
  wire var_text;
  wire var_wp;
  wire [159:0] var_val;
  wire [15:0] sw_rdata;
  wire [11:0] var_off = avs_address_i - `VAR_BASE;
  wire in_var = avs_address_i >= `VAR_BASE && var_off[11:6] < NVARS;
  wire av_req = avs_read_i | avs_write_i;
  wire wr_go = avs_write_i & ack_reg;

  // value counts as text when its first byte is printable
  wire wval_text = sd_wval[15:8] >= `TXT_LO && sd_wval[15:8] <= `TXT_HI;
  wire new_cmd = link_cycle_end_i & sd_en & (sd_cmd != prev_cmd_reg); // see [R15] see [R22]
  wire type_ok = var_text == wval_text; // see [R14]
  wire st_wr = new_cmd && sd_cmd == `CMD_WRITE && hit && !var_wp && type_ok;

  sd_var_store #(
    .NVARS(NVARS),
    .VW(VW)
  ) u_store (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sw_we_i(wr_go & in_var),
    .sw_var_i(var_off[6+VW-1:6]),
    .sw_word_i(avs_address_i[5:2]),
    .sw_wdata_i(avs_writedata_i[15:0]),
    .sw_rdata_o(sw_rdata),
    .name_i(sd_name),
    .hit_o(hit),
    .text_o(var_text),
    .wp_o(var_wp),
    .value_o(var_val),
    .wr_en_i(st_wr),
    .wr_value_i(sd_wval)
  );

  // ---------------------------------------------------------------
  // image size output
  // ---------------------------------------------------------------
  // sized from the config value this edge stores, so the flop
  // never lags a config write by a cycle
  wire cfg_wr = wr_go && avs_address_i == `CFG_OFS;
  wire [4:0] cfg_next = cfg_wr ? avs_writedata_i[4:0] : cfg_reg;
  wire [2:0] new_slots = {1'b0, cfg_next[`CFG_SLOTS_LSB+1:`CFG_SLOTS_LSB]} + 3'h1;
  wire new_flt = cfg_next[`CFG_FMT_LSB+1:`CFG_FMT_LSB] == `FMT_FLT;
  wire [4:0] new_slot_words = new_flt ? {new_slots, 2'b00} : {1'b0, new_slots, 1'b0};
  wire [4:0] image_words_next = cfg_next[`CFG_SD_BIT] ? (new_flt ? `SD_TOTAL_FLT : `SD_TOTAL_INT) : new_slot_words;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      image_words_reg <= `IMG_WORDS_RST;
    end else begin
      image_words_reg <= image_words_next; // see [R04] see [R21]
    end
  end

  assign image_words_o = image_words_reg;

  // ---------------------------------------------------------------
  // command execution, at a cycle boundary where the command word has changed
  // ---------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_cmd_reg <= `CMD_NULL;
      status_reg <= `ST_NULL;
      rd_valid_reg <= 1'b0;
      rd_val_reg <= 160'h0;
    end else if (!sd_en) begin
      prev_cmd_reg <= `CMD_NULL;
      status_reg <= `ST_NULL;
      rd_valid_reg <= 1'b0;
      rd_val_reg <= 160'h0;
    end else if (new_cmd) begin
      // result then holds until the command word changes again or shared data is disabled
      prev_cmd_reg <= sd_cmd; // see [R22]
      rd_valid_reg <= 1'b0; // see [R12]
      rd_val_reg <= 160'h0;
      case (sd_cmd) // see [R10]
        `CMD_NULL: begin
          status_reg <= `ST_NULL; // see [R13]
        end
        `CMD_READ: begin
          if (hit) begin
            status_reg <= `ST_OK;
            rd_valid_reg <= 1'b1; // see [R11] see [R12]
            rd_val_reg <= var_val; // see [R15]
          end else begin
            status_reg <= `ST_BADNAME;
          end
        end
        `CMD_WRITE: begin
          if (!hit) begin
            status_reg <= `ST_BADNAME;
          end else if (var_wp) begin
            status_reg <= `ST_WPROT; // see [R13]
          end else if (!type_ok) begin
            status_reg <= `ST_BADCMD; // see [R14]
          end else begin
            status_reg <= `ST_OK;
          end
        end
        default: begin
          status_reg <= `ST_BADCMD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // link side: output image in, input image out
  // ---------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < `IMG_MAX; i = i + 1) begin
        out_img_reg[i] <= 16'h0000;
      end
      cycle_cnt_reg <= 16'h0000;
    end else begin
      if (link_wr_i && link_waddr_i < size_words) begin
        out_img_reg[link_waddr_i] <= link_wdata_i; // see [R03] see [R05]
      end
      if (link_cycle_end_i) begin
        cycle_cnt_reg <= cycle_cnt_reg + 16'h0001;
      end
    end
  end

  always @* begin
    link_rd_next = 16'h0000;
    if (link_raddr_i < size_words) begin
      if (sd_en && link_raddr_i >= sd_in_base) begin
        if (rel == 5'h00) begin
          link_rd_next = {13'h0000, status_reg}; // see [R11]
        end else if (rel <= `SD_VAL_W && rd_valid_reg) begin
          link_rd_next = rd_val_reg[16*(rel-5'h01) +: 16]; // see [R12]
        end
      end else if (link_raddr_i < slot_words) begin
        link_rd_next = slot_in_reg[link_raddr_i[3:0]]; // see [R05]
      end
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_rdata_reg <= 16'h0000;
    end else if (link_rd_i) begin
      link_rdata_reg <= link_rd_next; // see [R03]
    end
  end

  assign link_rdata_o = link_rdata_reg;

  // ---------------------------------------------------------------
  // avalon slave, one wait state on every access
  // ---------------------------------------------------------------
  always @* begin
    av_next = 32'h0000_0000;
    if (avs_address_i == `CFG_OFS) begin
      av_next = {27'h0000000, cfg_reg};
    end else if (avs_address_i == `SIZE_OFS) begin
      av_next = {27'h0000000, size_words};
    end else if (avs_address_i == `STAT_OFS) begin
      av_next = {prev_cmd_reg, 12'h000, rd_valid_reg, status_reg};
    end else if (avs_address_i == `CNT_OFS) begin
      av_next = {16'h0000, cycle_cnt_reg};
    end else if (avs_address_i[11:6] == `SLOT_PAGE) begin
      av_next = {16'h0000, slot_in_reg[avs_address_i[5:2]]};
    end else if (avs_address_i[11:7] == `OUT_PAGE && avs_address_i[6:2] < `IMG_MAX) begin
      av_next = {16'h0000, out_img_reg[avs_address_i[6:2]]};
    end else if (in_var && avs_address_i[5:2] < `VAR_WORDS) begin
      av_next = {16'h0000, sw_rdata};
    end
  end

  // data is captured in the first cycle so the answer comes from a flop
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= av_req & ~ack_reg;
      if (avs_read_i && !ack_reg) begin
        rdata_reg <= av_next;
      end
    end
  end

  assign avs_waitrequest_o = av_req & ~ack_reg;
  assign avs_readdata_o = rdata_reg;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= `CFG_RST;
      for (i = 0; i < `SLOT_IN_MAX; i = i + 1) begin
        slot_in_reg[i] <= 16'h0000;
      end
    end else if (wr_go) begin
      if (avs_address_i == `CFG_OFS) begin
        cfg_reg <= avs_writedata_i[4:0]; // see [R01] see [R02] see [R06]
      end
      if (avs_address_i[11:6] == `SLOT_PAGE) begin
        slot_in_reg[avs_address_i[5:2]] <= avs_writedata_i[15:0];
      end
    end
  end

endmodule // sd_exchange

// ---- sim/sd_exchange_monitor.sv ----
`timescale 1ns/1ps
`include "sd_access_map.vh"
// ----------------------------------------
// port checks
// ----------------------------------------
module sd_exchange_monitor (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [11:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire link_rd_i,
  input wire [4:0] link_raddr_i,
  input wire [15:0] link_rdata_o,
  input wire link_cycle_end_i,
  input wire [4:0] image_words_o
);
  reg [4:0] cfg_reg;
  reg [15:0] ends_reg;
  wire rd_ack = avs_read_i && !avs_waitrequest_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of the config word, updated on the same edge as the design's
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= 5'h00;
      ends_reg <= 16'h0000;
    end else begin
      if (avs_write_i && !avs_waitrequest_o && avs_address_i[11:2] == 10'h000)
        cfg_reg <= avs_writedata_i[4:0];
      if (link_cycle_end_i)
        ends_reg <= ends_reg + 16'h0001;
    end
  end
  chk_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest longer than one cycle");
  chk_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  chk_cfg_readback: assert property (rd_ack && avs_address_i[11:2] == 10'h000 |-> avs_readdata_o == {27'h0, cfg_reg})
    else $error("config readback wrong");
  chk_size_plain: assert property (!cfg_reg[4] && cfg_reg[3:2] != 2'h2 |-> image_words_o == {2'b00, cfg_reg[1:0], 1'b0} + 5'h02)
    else $error("integer image size wrong");
  chk_size_float: assert property (!cfg_reg[4] && cfg_reg[3:2] == 2'h2 |-> image_words_o == {1'b0, cfg_reg[1:0], 2'b00} + 5'h04)
    else $error("float image size wrong");
  chk_size_shared: assert property (cfg_reg[4] |-> image_words_o == (cfg_reg[3:2] == 2'h2 ? 5'h1c : 5'h17))
    else $error("shared image size wrong");
  chk_rdata_hold: assert property (!link_rd_i |=> $stable(link_rdata_o))
    else $error("link read data moved without strobe");
  chk_range_zero: assert property (link_rd_i && link_raddr_i >= image_words_o |=> link_rdata_o == 16'h0000)
    else $error("read beyond image not zero");
  chk_cnt_match: assert property (rd_ack && avs_address_i[11:2] == 10'h003 |-> avs_readdata_o == {16'h0, ends_reg})
    else $error("cycle count wrong");
  cover property (cfg_reg[4] && link_cycle_end_i);
  cover property (link_rd_i && link_raddr_i >= image_words_o);
  cover property (avs_write_i && !avs_waitrequest_o);
  cover property (cfg_reg[3:2] == 2'h2 && link_rd_i);
endmodule // sd_exchange_monitor

bind sd_exchange sd_exchange_monitor mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .link_rd_i(link_rd_i), .link_raddr_i(link_raddr_i), .link_rdata_o(link_rdata_o),
  .link_cycle_end_i(link_cycle_end_i), .image_words_o(image_words_o));

// ---- sim/dp_master_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// cyclic master, one word per strobe
// ----------------------------------------
module dp_master_model (
  input wire core_clk_i,
  input wire [15:0] link_rdata_i,
  output reg link_wr_o,
  output reg [4:0] link_waddr_o,
  output reg [15:0] link_wdata_o,
  output reg link_rd_o,
  output reg [4:0] link_raddr_o,
  output reg link_cycle_end_o
);
  initial begin
    link_wr_o = 1'b0;
    link_waddr_o = 5'h1f;
    link_wdata_o = 16'hffff;
    link_rd_o = 1'b0;
    link_raddr_o = 5'h1f;
    link_cycle_end_o = 1'b0;
  end
  // released lines show the inverse so a stale value never passes
  task lw(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    link_wr_o <= 1'b1;
    link_waddr_o <= a;
    link_wdata_o <= d;
    @(posedge core_clk_i);
    link_wr_o <= 1'b0;
    link_waddr_o <= ~a;
    link_wdata_o <= ~d;
  endtask
  task lr(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    link_rd_o <= 1'b1;
    link_raddr_o <= a;
    @(posedge core_clk_i);
    link_rd_o <= 1'b0;
    link_raddr_o <= ~a;
    @(negedge core_clk_i);
    d = link_rdata_i;
  endtask
  task cyc;
    @(posedge core_clk_i);
    link_cycle_end_o <= 1'b1;
    @(posedge core_clk_i);
    link_cycle_end_o <= 1'b0;
  endtask
endmodule // dp_master_model

// ---- sim/fieldbus_shared_data_access_test.sv ----
`timescale 1ns/1ps
`include "sd_access_map.vh"
module fieldbus_shared_data_access_test;
  reg core_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [11:0] avs_address_i = 12'h000;
  reg avs_read_i = 1'b0;
  reg avs_write_i = 1'b0;
  reg [31:0] avs_writedata_i = 32'h0;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o;
  wire link_wr, link_rd, link_end;
  wire [4:0] link_waddr, link_raddr, image_words_o;
  wire [15:0] link_wdata, link_rdata;
  int fails = 0;
  int compares = 0;
  logic [15:0] st;
  logic [31:0] rv;
  logic [4:0] ob = 5'h08;
  logic [4:0] ib = 5'h08;
  always #20 core_clk_i = ~core_clk_i;
  sd_exchange #(.NVARS(4), .VW(2)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .link_wr_i(link_wr), .link_waddr_i(link_waddr), .link_wdata_i(link_wdata), .link_rd_i(link_rd),
    .link_raddr_i(link_raddr), .link_rdata_o(link_rdata), .link_cycle_end_i(link_end),
    .image_words_o(image_words_o));
  dp_master_model m (.core_clk_i(core_clk_i), .link_rdata_i(link_rdata), .link_wr_o(link_wr),
    .link_waddr_o(link_waddr), .link_wdata_o(link_wdata), .link_rd_o(link_rd), .link_raddr_o(link_raddr),
    .link_cycle_end_o(link_end));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one avalon access, held until the edge that sees waitrequest low
  task av(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_write_i <= we;
    avs_read_i <= !we;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(negedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    @(posedge core_clk_i);
    rv = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  function automatic logic [15:0] nm(input int v, input int w);
    return 16'h0a00 + 16'(v * 16 + w);
  endfunction
  function automatic logic [11:0] va(input int v, input int w);
    return `VAR_BASE + 12'(v * 64 + w * 4);
  endfunction
  // names and value loaded under a null command, then the command
  task sd_op(input logic [15:0] cmd, input int v, input logic [15:0] val0, input logic [2:0] exp);
    m.lw(ob, `CMD_NULL);
    for (int w = 0; w < 4; w++) m.lw(ob + 5'(1 + w), nm(v, w));
    for (int j = 0; j < 10; j++) m.lw(ob + 5'(5 + j), val0 + 16'(j));
    m.cyc();
    m.lr(ib, st);
    chk("null status", {29'h0, `ST_NULL}, {16'h0, st});
    m.lw(ob, cmd);
    m.cyc();
    m.lr(ib, st);
    chk("status", {29'h0, exp}, {16'h0, st});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    chk("image_words", 32'd2, {27'h0, image_words_o});
    av(1'b0, `CFG_OFS, 32'h0);
    chk("cfg", 32'h0, rv);
    av(1'b0, `CNT_OFS, 32'h0);
    chk("count", 32'h0, rv);
    $display("t_reset done");
  endtask
  task t_sizes;
    logic [31:0] e;
    for (int c = 0; c < 32; c++) begin
      e = c[4] ? (c[3:2] == 2 ? 28 : 23) : 32'((c[3:2] == 2 ? 4 : 2) * (c[1:0] + 1));
      av(1'b1, `CFG_OFS, 32'(c));
      chk("image_words", e, {27'h0, image_words_o});
      av(1'b0, `SIZE_OFS, 32'h0);
      chk("size reg", e, rv);
    end
    $display("t_sizes done");
  endtask
  task t_slots;
    av(1'b1, `CFG_OFS, 32'h09);
    for (int i = 0; i < 8; i++) begin
      av(1'b1, 12'h040 + 12'(4 * i), 32'h3000 + i);
      m.lr(5'(i), st);
      chk("slot in", 32'h3000 + i, {16'h0, st});
    end
    m.lr(5'h08, st);
    chk("beyond image", 32'h0, {16'h0, st});
    for (int i = 1; i < 8; i++) if (i % 4 != 0) begin
      m.lw(5'(i), 16'h4000 + 16'(i));
      av(1'b0, 12'h080 + 12'(4 * i), 32'h0);
      chk("slot out", 32'h4000 + i, rv);
    end
    av(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h0, rv);
    $display("t_slots done");
  endtask
  task t_shared;
    av(1'b1, `CFG_OFS, 32'h10);
    for (int v = 0; v < 3; v++) begin
      for (int w = 0; w < 4; w++) av(1'b1, va(v, w), {16'h0, nm(v, w)});
      av(1'b1, va(v, 4), 32'(v == 1 ? 2 : v == 2 ? 1 : 0)); // wp on 1, text on 2
      for (int j = 0; j < 10; j++) av(1'b1, va(v, 5 + j), 32'h1000 + v * 16 + j);
    end
    sd_op(`CMD_READ, 0, 16'h0000, `ST_OK);
    for (int j = 0; j < 10; j++) begin
      m.lr(5'(9 + j), st);
      chk("read field", 32'h1000 + j, {16'h0, st});
    end
    av(1'b0, `STAT_OFS, 32'h0);
    chk("stat reg", 32'h0001_0009, rv);
    av(1'b1, va(0, 5), 32'hbeef);
    m.cyc();
    m.lr(5'h09, st);
    chk("snapshot", 32'h1000, {16'h0, st});
    sd_op(`CMD_READ, 7, 16'h0000, `ST_BADNAME);
    m.lr(5'h09, st);
    chk("no read field", 32'h0, {16'h0, st});
    sd_op(16'h0005, 0, 16'h0000, `ST_BADCMD);
    sd_op(`CMD_WRITE, 1, 16'h0100, `ST_WPROT);
    av(1'b0, va(1, 5), 32'h0);
    chk("protected value", 32'h1010, rv);
    sd_op(`CMD_WRITE, 0, 16'h4100, `ST_BADCMD);
    sd_op(`CMD_WRITE, 2, 16'h0100, `ST_BADCMD);
    sd_op(`CMD_WRITE, 0, 16'h0100, `ST_OK);
    for (int j = 0; j < 10; j++) begin
      av(1'b0, va(0, 5 + j), 32'h0);
      chk("written value", 32'h0100 + j, rv);
    end
    m.lr(5'h09, st);
    chk("write read field", 32'h0, {16'h0, st});
    // float layout moves the shared data areas to words 13 and 16
    av(1'b1, `CFG_OFS, 32'h18);
    ob = 5'h0d;
    ib = 5'h10;
    sd_op(`CMD_READ, 0, 16'h0000, `ST_OK);
    for (int j = 0; j < 10; j++) begin
      m.lr(ib + 5'(1 + j), st);
      chk("float read field", 32'h0100 + j, {16'h0, st});
    end
    $display("t_shared done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_sizes;
    t_slots;
    t_shared;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fails++;
    summarize;
  end
endmodule // fieldbus_shared_data_access_test
